// >>> pbs_array.sv
// storage array with byte lanes and registered read data
`timescale 1ns/10ps
module pbs_array #(
    parameter int AW = 17,
    parameter int LW = 9,
    parameter int NL = 4
) (
    input  wire logic clock,
    pbs_mem_if.mem    mem
);
    logic [NL*LW-1:0] store [0:(1<<AW)-1];
    logic [NL*LW-1:0] rd_q;

    always_ff @(posedge clock) begin
        if (mem.wr_en) begin
            for (int i = 0; i < NL; i++) begin
                if (mem.wr_lane[i]) begin
                    store[mem.wr_addr][i*LW +: LW] <= mem.wr_data[i*LW +: LW];
                end
            end
        end
    end

    // write landing on the same edge passes through to the read
    wire fwd = mem.wr_en && (mem.wr_addr == mem.rd_addr);

    always_ff @(posedge clock) begin
        if (mem.rd_en) begin
            for (int i = 0; i < NL; i++) begin
                rd_q[i*LW +: LW] <= (fwd && mem.wr_lane[i]) ? mem.wr_data[i*LW +: LW]
                                                            : store[mem.rd_addr][i*LW +: LW];
            end
        end
    end

    assign mem.rd_data = rd_q;
endmodule : pbs_array

// >>> pbs_ctl_model.sv
// controller-side pin driver for the burst memory port
`timescale 1ns/10ps
module pbs_ctl_model (
    input  wire logic        clock,
    output logic [16:0]      address,
    output logic             advance_or_load,
    output logic             read_write,
    output logic             clock_hold_n,
    output logic [3:0]       byte_write_n,
    output logic             chip_select_low_a,
    output logic             chip_select_low_b,
    output logic             chip_select_high,
    output logic             output_enable_n,
    output logic [31:0]      data_lines_in,
    output logic [3:0]       parity_lines_in
);
    logic [35:0] wd_q [0:1];
    logic [35:0] bus_q = '0;
    logic [1:0]  wv_q  = 2'h0;
    logic        dir_q = 1'b0;
    logic        run_q = 1'b0;
    assign {parity_lines_in, data_lines_in} = bus_q;
    // kind 0 load, 1 advance, 2 deselect; sel picks the dropped select
    task automatic step(input int kind, input logic [16:0] a, input logic rw,
                        input logic [3:0] ln, input logic [35:0] wd, input logic hold,
                        input logic oen, input int sel);
        logic hd;
        @(posedge clock);
        // hold kept clear of pending writes
        hd = hold && wv_q == 2'h0;
        address           <= a;
        advance_or_load   <= kind == 1;
        read_write        <= rw;
        byte_write_n      <= ln;
        clock_hold_n      <= hd;
        chip_select_low_a <= kind == 2 && sel == 0;
        chip_select_low_b <= kind == 2 && sel == 1;
        chip_select_high  <= !(kind == 2 && sel == 2);
        output_enable_n   <= oen;
        // released bus shows the inverse of its last value
        bus_q <= wv_q[1] ? wd_q[1] : ~bus_q;
        wd_q[1] = wd_q[0];
        wd_q[0] = wd;
        wv_q = {wv_q[0], !hd && (kind == 0 ? !rw : kind == 1 && run_q && !dir_q)};
        if (!hd && kind == 0) begin
            dir_q = rw;
            run_q = 1'b1;
        end
        if (!hd && kind == 2) run_q = 1'b0;
    endtask : step
    initial begin
        address           = '0;
        advance_or_load   = 1'b0;
        read_write        = 1'b1;
        clock_hold_n      = 1'b0;
        byte_write_n      = 4'hf;
        chip_select_low_a = 1'b1;
        chip_select_low_b = 1'b0;
        chip_select_high  = 1'b1;
        output_enable_n   = 1'b0;
    end
endmodule : pbs_ctl_model

// >>> pbs_mem_if.sv
// array port between the pipeline and the storage
`timescale 1ns/10ps
interface pbs_mem_if #(
    parameter int AW = 17,
    parameter int DW = 36,
    parameter int NL = 4
);
    logic          wr_en;
    logic [NL-1:0] wr_lane;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic          rd_en;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    modport ctrl (output wr_en, wr_lane, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_lane, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : pbs_mem_if

// >>> pbs_pkg.sv
// types for the pipelined burst static memory port
`include "pbs_regs.svh"
package pbs_pkg;
    typedef enum logic [1:0] {
        PBS_OP_IDLE  = 2'b00,
        PBS_OP_READ  = 2'b01,
        PBS_OP_WRITE = 2'b10
    } pbs_op_t;
    typedef struct packed {
        pbs_op_t                        op;
        logic [`PBS_ADDR_W-1:0]         addr;
        logic [`PBS_LANES-1:0]          lane_we;
    } pbs_stage_t;
endpackage : pbs_pkg

// >>> pbs_port.sv
// pin-level pipelined burst static memory port
`timescale 1ns/10ps
`include "pbs_regs.svh"
// Overview of operation
// - address and control taken on one edge, data moves two cycles later
// - clock hold high freezes the burst state, pipeline and read data; the input sync flops keep sampling
// - deselect starts nothing new but finishes pipelined accesses
// - bus floats two cycles after a deselect or a write starts
// - address loads only on load, no hold, and full selection
// - load while deselected ends any running burst
// - advance steps the burst counter and ignores the address pins
// - up to four words per loaded address via the burst counter
// - burst order high selects interleaved, low selects linear
// - on load, read/write high means read, low means write
// - advance cycles ignore read/write, burst keeps load direction
// - one active-low write enable per 9-bit lane, only enabled lanes written
// - write data taken from bus two cycles after the write cycle
// - lane enables ignored when read/write is high on a load; advance cycles of a write burst use them
// - output enable high floats the pins two clocks later, after its two sync flops
// - write data and read data both registered on the rising edge
// - two chip selects active low, one active high, same effect
module pbs_port
    import pbs_pkg::*;
#(
    parameter int AW = `PBS_ADDR_W,
    parameter int NL = `PBS_LANES,
    parameter int LW = `PBS_LANE_W
) (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic [AW-1:0]        address,
    input  wire logic                 advance_or_load,
    input  wire logic                 read_write,
    input  wire logic                 clock_hold_n,
    input  wire logic [NL-1:0]        byte_write_n,
    input  wire logic                 chip_select_low_a,
    input  wire logic                 chip_select_low_b,
    input  wire logic                 chip_select_high,
    input  wire logic                 burst_order_select,
    input  wire logic                 output_enable_n,
    input  wire logic [NL*(LW-1)-1:0] data_lines_in,
    input  wire logic [NL-1:0]        parity_lines_in,
    output logic      [NL*(LW-1)-1:0] data_lines_out,
    output logic      [NL-1:0]        parity_lines_out,
    output logic                      data_lines_oe
);
    localparam int DW = NL * LW;
    localparam int BW = `PBS_BURST_W;

    // pins pass two flip-flops before any logic reads them
    logic [AW-1:0]       addr_s1, addr_s2;
    logic                adv_s1, adv_s2, rw_s1, rw_s2, hold_s1, hold_s2;
    logic [NL-1:0]       bw_s1, bw_s2;
    logic [2:0]          cs_s1, cs_s2;
    logic                order_s1, order_s2, oe_s1, oe_s2;
    logic [DW-1:0]       din_s1, din_s2;
    logic [DW-1:0]       din_merged;

    always_ff @(posedge clock) begin
        addr_s1  <= address;
        addr_s2  <= addr_s1;
        adv_s1   <= advance_or_load;
        adv_s2   <= adv_s1;
        rw_s1    <= read_write;
        rw_s2    <= rw_s1;
        hold_s1  <= clock_hold_n;
        hold_s2  <= hold_s1;
        bw_s1    <= byte_write_n;
        bw_s2    <= bw_s1;
        cs_s1    <= {chip_select_high, chip_select_low_b, chip_select_low_a};
        cs_s2    <= cs_s1;
        order_s1 <= burst_order_select;
        order_s2 <= order_s1;
        oe_s1    <= output_enable_n;
        oe_s2    <= oe_s1;
        din_s1   <= din_merged;
        din_s2   <= din_s1;
    end

    // lanes regrouped as eight data bits plus one parity bit each
    always_comb begin
        din_merged = '0;
        for (int i = 0; i < NL; i++) begin
            din_merged[i*LW +: LW] = {parity_lines_in[i], data_lines_in[i*(LW-1) +: LW-1]};
        end
    end

    wire run = ~hold_s2;
    wire selected = ~cs_s2[0] & ~cs_s2[1] & cs_s2[2];
    wire load_cyc = run & ~adv_s2 & selected;
    wire desel_cyc = run & ~adv_s2 & ~selected;
    wire adv_cyc = run & adv_s2;

    // burst state
    logic [AW-1:0] base_q, base_d;
    logic [BW-1:0] cnt_q, cnt_d;
    logic          burst_q, burst_d;
    logic          dir_wr_q, dir_wr_d;

    always_comb begin
        base_d   = base_q;
        cnt_d    = cnt_q;
        burst_d  = burst_q;
        dir_wr_d = dir_wr_q;
        if (load_cyc) begin
            base_d   = addr_s2;
            cnt_d    = '0;
            burst_d  = 1'b1;
            dir_wr_d = ~rw_s2;
        end else if (desel_cyc) begin
            burst_d  = 1'b0;
        // advance steps the counter, address pins ignored
        end else if (adv_cyc && burst_q) begin
            cnt_d    = cnt_q + BW'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            base_q   <= '0;
            cnt_q    <= '0;
            burst_q  <= 1'b0;
            dir_wr_q <= 1'b0;
        end else begin
            base_q   <= base_d;
            cnt_q    <= cnt_d;
            burst_q  <= burst_d;
            dir_wr_q <= dir_wr_d;
        end
    end

    // only the two low bits change; linear adds, interleaved xors
    wire [BW-1:0] step_cnt  = cnt_q + BW'(1);
    wire [BW-1:0] lin_low   = base_q[BW-1:0] + step_cnt;
    wire [BW-1:0] ilv_low   = base_q[BW-1:0] ^ step_cnt;
    wire [BW-1:0] burst_low = order_s2 ? ilv_low : lin_low;
    wire [AW-1:0] adv_addr  = {base_q[AW-1:BW], burst_low};

    // stage issued this cycle
    pbs_stage_t issue;
    always_comb begin
        issue = '{op: PBS_OP_IDLE, addr: '0, lane_we: '0};
        if (load_cyc) begin
            issue.op      = rw_s2 ? PBS_OP_READ : PBS_OP_WRITE;
            issue.addr    = addr_s2;
            issue.lane_we = rw_s2 ? '0 : ~bw_s2;
        end else if (adv_cyc && burst_q) begin
            issue.op      = dir_wr_q ? PBS_OP_WRITE : PBS_OP_READ;
            issue.addr    = adv_addr;
            issue.lane_we = dir_wr_q ? ~bw_s2 : '0;
        end
    end

    // two-stage pipeline; deselect issues idle but drains
    pbs_stage_t stg1_q, stg2_q;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stg1_q <= '{op: PBS_OP_IDLE, addr: '0, lane_we: '0};
            stg2_q <= '{op: PBS_OP_IDLE, addr: '0, lane_we: '0};
        end else if (run) begin
            stg1_q <= issue;
            stg2_q <= stg1_q;
        end
    end

    pbs_mem_if #(.AW(AW), .DW(DW), .NL(NL)) mif ();

    // write data from the bus two cycles after the write cycle
    assign mif.wr_en   = run & (stg2_q.op == PBS_OP_WRITE);
    assign mif.wr_lane = stg2_q.lane_we;
    assign mif.wr_addr = stg2_q.addr;
    // write data registered on the rising edge
    assign mif.wr_data = din_s2;
    // read launched one cycle ahead so data is registered at stage two
    assign mif.rd_en   = run & (stg1_q.op == PBS_OP_READ);
    assign mif.rd_addr = stg1_q.addr;

    pbs_array #(.AW(AW), .LW(LW), .NL(NL)) u_array (
        .clock (clock),
        .mem   (mif.mem)
    );

    // bus driven only while stage two holds a read
    // read word appears two cycles after load or advance
    wire drive_rd = (stg2_q.op == PBS_OP_READ);

    always_comb begin
        data_lines_out   = '0;
        parity_lines_out = '0;
        for (int i = 0; i < NL; i++) begin
            data_lines_out[i*(LW-1) +: LW-1] = mif.rd_data[i*LW +: LW-1];
            parity_lines_out[i]              = mif.rd_data[i*LW + LW-1];
        end
    end

    // output enable gates the drive after passing its two sync flops
    assign data_lines_oe = drive_rd & ~oe_s2;

    // issued read reaches the bus two edges later
    property p_read_pipe;
        @(posedge clock) disable iff (sys_rst)
        (load_cyc && rw_s2) ##1 (run) |-> ##1 (stg2_q.op == PBS_OP_READ);
    endproperty
    a_read_pipe: assert property (p_read_pipe) else $error("read not at stage two");

    property p_hold_freeze;
        @(posedge clock) disable iff (sys_rst)
        !run |=> ($stable(stg2_q) && $stable(cnt_q) && $stable(base_q));
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("state moved on hold");

    property p_desel_idle;
        @(posedge clock) disable iff (sys_rst)
        desel_cyc |=> (stg1_q.op == PBS_OP_IDLE) && !burst_q;
    endproperty
    a_desel_idle: assert property (p_desel_idle) else $error("deselect issued op");

    property p_float_write;
        @(posedge clock) disable iff (sys_rst)
        (stg2_q.op != PBS_OP_READ) |-> !data_lines_oe;
    endproperty
    a_float_write: assert property (p_float_write) else $error("bus driven off read");

    property p_addr_load;
        @(posedge clock) disable iff (sys_rst)
        !load_cyc |=> base_q == $past(base_q);
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address loaded wrongly");

    property p_adv_step;
        @(posedge clock) disable iff (sys_rst)
        (adv_cyc && burst_q) |=> cnt_q == $past(cnt_q) + 2'd1;
    endproperty
    a_adv_step: assert property (p_adv_step) else $error("burst counter not stepped");

    property p_dir_keep;
        @(posedge clock) disable iff (sys_rst)
        (adv_cyc && burst_q) |=> ((stg1_q.op == PBS_OP_WRITE) == $past(dir_wr_q));
    endproperty
    a_dir_keep: assert property (p_dir_keep) else $error("burst direction changed");

    property p_read_no_we;
        @(posedge clock) disable iff (sys_rst)
        (stg1_q.op == PBS_OP_READ) |-> (stg1_q.lane_we == '0);
    endproperty
    a_read_no_we: assert property (p_read_no_we) else $error("lane enable on read");

    property p_oe_gate;
        @(posedge clock) disable iff (sys_rst)
        oe_s2 |-> !data_lines_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("driven with enable high");

    property p_high_bits;
        @(posedge clock) disable iff (sys_rst)
        (stg1_q.op != PBS_OP_IDLE) && burst_q |-> stg1_q.addr[AW-1:BW] == base_q[AW-1:BW];
    endproperty
    a_high_bits: assert property (p_high_bits) else $error("burst changed high bits");

    property p_desel_float;
        @(posedge clock) disable iff (sys_rst)
        desel_cyc ##1 run |=> !data_lines_oe;
    endproperty
    a_desel_float: assert property (p_desel_float) else $error("bus driven after deselect");

    property p_write_float;
        @(posedge clock) disable iff (sys_rst)
        (load_cyc && !rw_s2) ##1 run |=> !data_lines_oe;
    endproperty
    a_write_float: assert property (p_write_float) else $error("bus driven after write");

    property p_read_drive;
        @(posedge clock) disable iff (sys_rst)
        (load_cyc && rw_s2) ##1 run |=> (data_lines_oe == !oe_s2);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read word not driven");

    property p_write_commit;
        @(posedge clock) disable iff (sys_rst)
        (load_cyc && !rw_s2) ##1 run ##1 run |-> mif.wr_en && (mif.wr_addr == $past(addr_s2, 2));
    endproperty
    a_write_commit: assert property (p_write_commit) else $error("write not committed");

    property p_lane_map;
        @(posedge clock) disable iff (sys_rst)
        (load_cyc && !rw_s2) |=> (stg1_q.lane_we == ~$past(bw_s2));
    endproperty
    a_lane_map: assert property (p_lane_map) else $error("lane enables lost");

    property p_load_dir;
        @(posedge clock) disable iff (sys_rst)
        load_cyc |=> (stg1_q.op == ($past(rw_s2) ? PBS_OP_READ : PBS_OP_WRITE));
    endproperty
    a_load_dir: assert property (p_load_dir) else $error("load direction wrong");

    property p_addr_take;
        @(posedge clock) disable iff (sys_rst)
        load_cyc |=> (base_q == $past(addr_s2)) && (cnt_q == '0);
    endproperty
    a_addr_take: assert property (p_addr_take) else $error("address not loaded");

    property p_lin_step;
        @(posedge clock) disable iff (sys_rst)
        (adv_cyc && burst_q && !order_s2) |=> (stg1_q.addr[BW-1:0] == base_q[BW-1:0] + cnt_q);
    endproperty
    a_lin_step: assert property (p_lin_step) else $error("linear order wrong");

    property p_ilv_step;
        @(posedge clock) disable iff (sys_rst)
        (adv_cyc && burst_q && order_s2) |=> (stg1_q.addr[BW-1:0] == (base_q[BW-1:0] ^ cnt_q));
    endproperty
    a_ilv_step: assert property (p_ilv_step) else $error("interleaved order wrong");

    property p_select_mix;
        @(posedge clock) disable iff (sys_rst)
        (run && !adv_s2 && (cs_s2[0] || cs_s2[1] || !cs_s2[2])) |=> (stg1_q.op == PBS_OP_IDLE);
    endproperty
    a_select_mix: assert property (p_select_mix) else $error("deselect started op");

    property p_adv_idle;
        @(posedge clock) disable iff (sys_rst)
        (adv_cyc && !burst_q) |=> (stg1_q.op == PBS_OP_IDLE);
    endproperty
    a_adv_idle: assert property (p_adv_idle) else $error("advance without burst");

    property p_hold_out;
        @(posedge clock) disable iff (sys_rst)
        !run |=> $stable(data_lines_out) && $stable(parity_lines_out);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("output moved on hold");
endmodule : pbs_port

// >>> pbs_regs.svh
// constants for the pipelined burst static memory port
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH
`define PBS_ADDR_W      17
`define PBS_LANES       4
`define PBS_LANE_W      9
`define PBS_PIPE_DEPTH  2
`define PBS_BURST_LEN   4
`define PBS_BURST_W     2
`endif

// >>> testbench.sv
// self-checking bench for the pipelined burst memory port
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic hn, adv, rw, ca, cb, ch, oen;
        logic [3:0] ln;
        logic [16:0] a;
        logic [35:0] d;
    } pbs_tb_pins_t;
    logic         clock = 1'b0;
    logic         sys_rst = 1'b1;
    logic         burst_order_select = 1'b0;
    logic [16:0]  address;
    logic         advance_or_load, read_write, clock_hold_n, output_enable_n;
    logic         chip_select_low_a, chip_select_low_b, chip_select_high;
    logic [3:0]   byte_write_n, parity_lines_in, parity_lines_out;
    logic [31:0]  data_lines_in, data_lines_out;
    logic         data_lines_oe;
    pbs_tb_pins_t s1, s2;
    logic [35:0]  mem [0:63];
    logic [35:0]  exp_word;
    logic         exp_oe_q, dir, bact;
    logic [16:0]  a1, a2, base;
    logic [3:0]   l1, l2;
    int           op1, op2, cnt;
    int           err_total = 0;
    int           total_checks = 0;
    logic [31:0]  rng_q = 32'h0000_4a5a;

    always #50 clock = ~clock;
    pbs_port u_dut (.clock, .sys_rst, .address, .advance_or_load, .read_write,
        .clock_hold_n, .byte_write_n, .chip_select_low_a, .chip_select_low_b,
        .chip_select_high, .burst_order_select, .output_enable_n, .data_lines_in,
        .parity_lines_in, .data_lines_out, .parity_lines_out, .data_lines_oe);
    pbs_ctl_model u_ctl (.clock, .address, .advance_or_load, .read_write, .clock_hold_n,
        .byte_write_n, .chip_select_low_a, .chip_select_low_b, .chip_select_high,
        .output_enable_n, .data_lines_in, .parity_lines_in);

    function automatic logic [31:0] rnd();
        rng_q ^= rng_q << 13;
        rng_q ^= rng_q >> 17;
        rng_q ^= rng_q << 5;
        return rng_q;
    endfunction : rnd
    function automatic logic [35:0] rnd36();
        logic [31:0] h;
        h = rnd();
        return {h[3:0], rnd()};
    endfunction : rnd36

    // reference pipeline: two sync stages, then load, stage, output
    always @(posedge clock) begin
        if (sys_rst) begin
            op1 = 0;
            op2 = 0;
            exp_oe_q = 1'b0;
            bact = 1'b0;
        end else if (!s2.hn) begin
            if (op2 == 2) for (int i = 0; i < 4; i++) if (!l2[i]) begin
                mem[a2[5:0]][8*i+:8] = s2.d[8*i+:8];
                mem[a2[5:0]][32+i] = s2.d[32+i];
            end
            // read word out one stage after issue
            exp_oe_q = op1 == 1;
            if (op1 == 1) exp_word = mem[a1[5:0]];
            op2 = op1;
            a2 = a1;
            l2 = l1;
            op1 = 0;
            if (!s2.adv && !s2.ca && !s2.cb && s2.ch) begin
                base = s2.a;
                cnt = 0;
                dir = s2.rw;
                bact = 1'b1;
                op1 = dir ? 1 : 2;
                a1 = base;
                l1 = s2.ln;
            end else if (!s2.adv) begin
                bact = 1'b0;
            end else if (bact) begin
                cnt = (cnt + 1) % 4;
                a1 = {base[16:2], burst_order_select ? base[1:0] ^ 2'(cnt)
                                                     : base[1:0] + 2'(cnt)};
                op1 = dir ? 1 : 2;
                l1 = s2.ln;
            end
        end
        s2 = s1;
        s1 = {clock_hold_n, advance_or_load, read_write, chip_select_low_a,
              chip_select_low_b, chip_select_high, output_enable_n, byte_write_n,
              address, parity_lines_in, data_lines_in};
    end

    task automatic chk_bit(input logic got, input logic want);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("[FAIL] %0t bus enable %b expected %b", $time, got, want);
        end
    endtask : chk_bit
    task automatic chk_word(input logic [35:0] got, input logic [35:0] want);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("[FAIL] %0t read word %h expected %h", $time, got, want);
        end
    endtask : chk_word

    always @(negedge clock) begin
        if (!sys_rst) begin
            chk_bit(data_lines_oe, exp_oe_q && !s2.oen);
            if (exp_oe_q) chk_word({parity_lines_out, data_lines_out}, exp_word);
        end
    end

    task automatic idle(input int n);
        repeat (n) u_ctl.step(2, '0, 1'b1, 4'hf, '0, 1'b0, 1'b0, 0);
    endtask : idle
    task automatic run_random(input int n);
        logic [31:0] r;
        int          k;
        for (int i = 0; i < n; i++) begin
            r = rnd();
            k = r[2:0] < 3 ? 0 : r[2:0] < 6 ? 1 : 2;
            u_ctl.step(k, {11'h000, r[8:3]}, r[9], r[13:10], {r[31:14], r[17:0]},
                       r[20:18] == 0, r[24:21] == 0, int'(r[26:25]) % 3);
        end
    endtask : run_random
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
    initial begin
        idle(12);
        sys_rst <= 1'b0;
        // fill every word with full-width linear bursts
        for (int b = 0; b < 16; b++) begin
            u_ctl.step(0, 17'(b * 4), 1'b0, 4'h0, rnd36(), 1'b0, 1'b0, 0);
            repeat (3) u_ctl.step(1, 17'(rnd()), 1'(rnd()), 4'h0, rnd36(), 1'b0, 1'b0, 0);
        end
        run_random(400);
        idle(6);
        sys_rst <= 1'b1;
        burst_order_select <= 1'b1;
        idle(12);
        sys_rst <= 1'b0;
        run_random(400);
        idle(6);
        wrap_up();
    end
endmodule : testbench
